// *** hw/mcg_pkg.sv ***
package mcg_pkg;

    // memory geometry
    localparam int                   MCG_ADDR_W       = 10;
    localparam int                   MCG_DATA_W       = 16;
    localparam int                   MCG_MEM_WORDS    = 1024;
    localparam int                   MCG_LINES        = 8;
    localparam int                   MCG_PINS         = 4;

    // region boundaries, word addresses
    localparam logic [9:0]           MCG_CFG_A_LO     = 10'h000;
    localparam logic [9:0]           MCG_CFG_A_HI     = 10'h010;
    localparam logic [9:0]           MCG_USER1_LO     = 10'h012;
    localparam logic [9:0]           MCG_USER1_HI     = 10'h03E;
    localparam logic [9:0]           MCG_RSVD_LO      = 10'h040;
    localparam logic [9:0]           MCG_RSVD_HI      = 10'h04E;
    localparam logic [9:0]           MCG_CFG_B_LO     = 10'h050;
    localparam logic [9:0]           MCG_CFG_B_HI     = 10'h07E;
    localparam logic [9:0]           MCG_USER2_LO     = 10'h080;
    localparam logic [9:0]           MCG_USER2_HI     = 10'h3FF;

    // configuration words inside the writable configuration area
    localparam logic [9:0]           MCG_PIN_WORD     = 10'h00A;
    localparam logic [9:0]           MCG_INV_WORD     = 10'h00B;
    localparam logic [9:0]           MCG_CKSUM_WORD   = 10'h07E;
    localparam int                   MCG_PIN_FIELD_W  = 4;

    typedef enum logic [1:0] {
        REG_USER     = 2'b00,
        REG_CONFIG   = 2'b01,
        REG_RESERVED = 2'b10,
        REG_GAP      = 2'b11
    } mcg_region_type;

    typedef enum logic [3:0] {
        PF_DRIVE_EN  = 4'h0,
        PF_RX_LED    = 4'h1,
        PF_TX_LED    = 4'h2,
        PF_SUSPEND_N = 4'h3,
        PF_LOW       = 4'h4,
        PF_HIGH      = 4'h5
    } mcg_pin_func_type;

    typedef enum logic [1:0] {
        SC_IDLE = 2'b00,
        SC_SCAN = 2'b01,
        SC_LOAD = 2'b10
    } mcg_scan_type;

    // factory contents: pins 3..0 = suspend, tx led, rx led, drive enable
    localparam logic [15:0]          MCG_PIN_DEFAULT  = 16'h3210;
    localparam logic [15:0]          MCG_INV_DEFAULT  = 16'h0000;
    localparam logic [15:0]          MCG_CKSUM_DEFAULT = MCG_PIN_DEFAULT + MCG_INV_DEFAULT;

    // memory request from the host-facing side
    typedef struct packed {
        logic [9:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mcg_req_type;

    // modem activity inputs that the configurable pins can show
    typedef struct packed {
        logic rs485_tx_busy;
        logic rx_activity;
        logic tx_activity;
        logic usb_suspend;
    } mcg_act_type;

    // line order in the inversion word, bit 0 upward
    localparam int MCG_L_TXD = 0;
    localparam int MCG_L_RXD = 1;
    localparam int MCG_L_RTS = 2;
    localparam int MCG_L_CTS = 3;
    localparam int MCG_L_DTR = 4;
    localparam int MCG_L_DSR = 5;
    localparam int MCG_L_DCD = 6;
    localparam int MCG_L_RI  = 7;

    // lines whose pin is an input to the device
    localparam logic [7:0] MCG_PIN_IS_INPUT = 8'b1110_1010;

    // one region per address
    function automatic mcg_region_type mcg_region(input logic [9:0] a);
        if (a <= MCG_CFG_A_HI || (a >= MCG_CFG_B_LO && a <= MCG_CFG_B_HI))
            return REG_CONFIG;
        else if ((a >= MCG_USER1_LO && a <= MCG_USER1_HI) || a >= MCG_USER2_LO)
            return REG_USER;
        else if (a >= MCG_RSVD_LO && a <= MCG_RSVD_HI)
            return REG_RESERVED;
        else
            return REG_GAP;
    endfunction

endpackage

// *** hw/mcg_line_polarity.sv ***
`timescale 1ns/1ps
module mcg_line_polarity
    import mcg_pkg::*;
#(
    parameter int LINES = MCG_LINES
)(
    input  wire logic             core_clk,  // device clock
    input  wire logic             reset_n,   // async reset
    input  wire logic [LINES-1:0] line_in,   // core level or pin level per line
    input  wire logic [LINES-1:0] invert,    // inversion enable per line
    output logic      [LINES-1:0] line_out   // corrected level per line
);

    initial
    begin
        if (LINES != MCG_LINES)
            $error("mcg_line_polarity: LINES must equal eight");
    end

    typedef struct packed {
        logic [LINES-1:0] sync1;
        logic [LINES-1:0] sync2;
        logic [LINES-1:0] outq;
    } mcg_pol_state_type;

    mcg_pol_state_type q;
    mcg_pol_state_type next_q;

    // pin inputs take two flops first, core outputs go straight to the output flop
    always_comb
    begin
        next_q       = q;
        next_q.sync1 = line_in;
        next_q.sync2 = q.sync1;
        for (int i = 0; i < LINES; i++)
        begin
            if (MCG_PIN_IS_INPUT[i])
                next_q.outq[i] = q.sync2[i] ^ invert[i];
            else
                next_q.outq[i] = line_in[i] ^ invert[i];
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= next_q;
    end

    assign line_out = q.outq;

endmodule // mcg_line_polarity

// *** hw/mcg_region_guard.sv ***
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// - words 0x12-0x3E and 0x80-0x3FF are plain user storage, read and write.
// - words 0x00-0x10 and 0x50-0x7E are writable configuration storage.
// - writes to words 0x40-0x4E are refused and leave contents unchanged.
// - user words never enter the checksum.
// - one checksum spans both configuration areas; a stale checksum is flagged.
// - factory pin functions: drive enable, rx led, tx led, suspend indicator.
// - suspend indicator pin is low while suspended, high otherwise.
// - eight uart and modem lines each have an inversion bit, default off.
// - after power-on or bus reset, scan memory and load settings.
module mcg_region_guard
    import mcg_pkg::*;
#(
    parameter int MEM_WORDS = MCG_MEM_WORDS
)(
    input  wire logic                  core_clk,       // device clock, 50 MHz
    input  wire logic                  reset_n,        // power-on reset, async
    input  wire logic                  usb_bus_reset,  // bus reset seen by usb core
    input  wire mcg_req_type           req,            // memory read or write request
    input  wire mcg_act_type           act,            // activity for pin functions
    input  wire logic [MCG_LINES-1:0]  line_in,        // uart lines before polarity
    output logic      [15:0]           mem_rdata,      // read data, cycle after read
    output logic                       wr_done,        // write accepted pulse
    output logic                       wr_fail,        // write refused pulse
    output logic                       cksum_ok,       // checksum matches
    output logic                       cfg_loaded,     // settings loaded since reset
    output logic      [MCG_PINS-1:0]   cfg_pin,        // configurable pins 3..0
    output logic      [MCG_LINES-1:0]  line_out        // uart lines after polarity
);

    // elaboration checks: geometry the logic is built for
    initial
    begin
        if (MEM_WORDS != MCG_MEM_WORDS)
            $error("mcg_region_guard: MEM_WORDS must be 1024");
        if (MCG_PINS * MCG_PIN_FIELD_W > MCG_DATA_W)
            $error("mcg_region_guard: pin functions do not fit one word");
        if (MCG_LINES > MCG_DATA_W)
            $error("mcg_region_guard: inversion bits do not fit one word");
        if (MCG_CKSUM_WORD != MCG_CFG_B_HI)
            $error("mcg_region_guard: checksum word must close the scan");
    end

    // one register image: memory, scan walker, answers, loaded settings
    typedef struct packed {
        logic [MCG_MEM_WORDS-1:0][15:0]                mem;
        mcg_scan_type                                  scan;
        logic [9:0]                                    idx;
        logic [15:0]                                   sum;
        logic [15:0]                                   rdata;
        logic                                          done;
        logic                                          fail;
        logic                                          ok;
        logic                                          loaded;
        logic [MCG_PINS-1:0][MCG_PIN_FIELD_W-1:0]      pin_func;
        logic [MCG_LINES-1:0]                          inv;
        logic [MCG_PINS-1:0]                           pin;
    } mcg_state_type;

    mcg_state_type  q;
    mcg_state_type  next_q;
    mcg_region_type wr_region;
    logic           sum_ok;

    // level of one configurable pin for a given function
    function automatic logic pin_level(input logic [3:0] f, input mcg_act_type a);
        case (f)
            PF_DRIVE_EN:  return a.rs485_tx_busy;
            PF_RX_LED:    return ~a.rx_activity;
            PF_TX_LED:    return ~a.tx_activity;
            PF_SUSPEND_N: return ~a.usb_suspend;
            PF_LOW:       return 1'b0;
            default:      return 1'b1;
        endcase
    endfunction

    // region of the request and verdict of the running sum
    assign wr_region = mcg_region(req.addr);
    assign sum_ok    = (q.sum == q.mem[MCG_CKSUM_WORD]);

    always_comb
    begin
        next_q      = q;
        // write answers are one-cycle pulses
        next_q.done = 1'b0;
        next_q.fail = 1'b0;

        // reads: any mapped word, gaps read as zero
        // a read sees memory as it stood before this edge
        if (req.rd)
        begin
            if (mcg_region(req.addr) == REG_GAP)
                next_q.rdata = 16'h0000;
            else
                next_q.rdata = q.mem[req.addr];
        end

        // scan walks words 0x00-0x7E and sums the configuration words among them
        unique case (q.scan)
            SC_IDLE:
            begin
                next_q.idx = q.idx;
            end
            SC_SCAN:
            begin
                // the checksum word itself stays out of the sum
                if (mcg_region(q.idx) == REG_CONFIG && q.idx != MCG_CKSUM_WORD)
                    next_q.sum = q.sum + q.mem[q.idx];
                if (q.idx == MCG_CFG_B_HI)
                    next_q.scan = SC_LOAD;
                else
                    next_q.idx = q.idx + 10'h001;
            end
            SC_LOAD:
            begin
                next_q.ok     = sum_ok;
                next_q.loaded = 1'b1;
                next_q.scan   = SC_IDLE;
                // stored settings if intact, factory settings otherwise
                // so a half-written image cannot misconfigure the pins
                for (int p = 0; p < MCG_PINS; p++)
                begin
                    if (sum_ok)
                        next_q.pin_func[p] = q.mem[MCG_PIN_WORD][p*MCG_PIN_FIELD_W +: MCG_PIN_FIELD_W];
                    else
                        next_q.pin_func[p] = MCG_PIN_DEFAULT[p*MCG_PIN_FIELD_W +: MCG_PIN_FIELD_W];
                end
                if (sum_ok)
                    next_q.inv = q.mem[MCG_INV_WORD][MCG_LINES-1:0];
                else
                    next_q.inv = MCG_INV_DEFAULT[MCG_LINES-1:0];
            end
            default:
            begin
                next_q.scan = SC_IDLE;
            end
        endcase

        // writes: user and configuration accepted, others refused
        // reserved and gap words: memory untouched, failure pulse
        // a config write mid-scan restarts it, so no half-updated image is judged
        if (req.wr)
        begin
            if (wr_region == REG_USER || wr_region == REG_CONFIG)
            begin
                next_q.mem[req.addr] = req.wdata;
                next_q.done          = 1'b1;
            end
            else
            begin
                next_q.fail = 1'b1;
            end
            // configuration changed: checksum must be re-evaluated
            if (wr_region == REG_CONFIG)
            begin
                next_q.scan = SC_SCAN;
                next_q.idx  = MCG_CFG_A_LO;
                next_q.sum  = 16'h0000;
            end
        end

        // bus reset reloads everything from memory
        // loaded stays low until the new scan reaches its load cycle
        if (usb_bus_reset)
        begin
            next_q.scan   = SC_SCAN;
            next_q.idx    = MCG_CFG_A_LO;
            next_q.sum    = 16'h0000;
            next_q.loaded = 1'b0;
        end

        // pin drivers follow the loaded functions, one cycle behind act
        for (int p = 0; p < MCG_PINS; p++)
        begin
            next_q.pin[p] = pin_level(q.pin_func[p], act);
        end
    end

    // state register; memory powers up with factory contents
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // factory image: pin word, inversion word and their checksum
            q                      <= '0;
            q.mem[MCG_PIN_WORD]    <= MCG_PIN_DEFAULT;
            q.mem[MCG_INV_WORD]    <= MCG_INV_DEFAULT;
            q.mem[MCG_CKSUM_WORD]  <= MCG_CKSUM_DEFAULT;
            q.pin_func             <= MCG_PIN_DEFAULT[MCG_PINS*MCG_PIN_FIELD_W-1:0];
            q.pin                  <= 4'b1111;
            q.scan                 <= SC_SCAN;
        end
        else
        begin
            q <= next_q;
        end
    end

    // uart line polarity
    mcg_line_polarity #(
        .LINES    (MCG_LINES)
    ) u_polarity (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .line_in  (line_in),
        .invert   (q.inv),
        .line_out (line_out)
    );

    // outputs come straight from the state register
    assign mem_rdata  = q.rdata;
    assign wr_done    = q.done;
    assign wr_fail    = q.fail;
    assign cksum_ok   = q.ok;
    assign cfg_loaded = q.loaded;
    assign cfg_pin    = q.pin;

endmodule // mcg_region_guard

// *** verification/mcg_region_guard_chk.sv ***
`timescale 1ns/1ps
module mcg_region_guard_chk
    import mcg_pkg::*;
(
    input wire logic        core_clk,      // device clock
    input wire logic        reset_n,       // async reset
    input wire logic        usb_bus_reset, // bus reset
    input wire mcg_req_type req,           // memory request
    input wire logic [15:0] mem_rdata,     // read data
    input wire logic        wr_done,       // write accepted
    input wire logic        wr_fail,       // write refused
    input wire logic        cfg_loaded     // scan finished
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic in_user;
    logic in_cfg;
    logic in_rsvd;
    logic in_gap;

    // own region decode of the request address
    assign in_user = (req.addr >= MCG_USER1_LO && req.addr <= MCG_USER1_HI) || req.addr >= MCG_USER2_LO;
    assign in_cfg  = req.addr <= MCG_CFG_A_HI || (req.addr >= MCG_CFG_B_LO && req.addr <= MCG_CFG_B_HI);
    assign in_rsvd = req.addr >= MCG_RSVD_LO && req.addr <= MCG_RSVD_HI;
    assign in_gap  = !(in_user || in_cfg || in_rsvd);

    // write answers and read data
    AST_WR_ANSWER: assert property (req.wr |=> wr_done != wr_fail)
        else $error("write without exactly one answer");
    AST_RSVD_FAIL: assert property (req.wr && in_rsvd |=> wr_fail)
        else $error("reserved write not refused");
    AST_USER_OK: assert property (req.wr && in_user |=> wr_done)
        else $error("user write not accepted");
    AST_CFG_OK: assert property (req.wr && in_cfg |=> wr_done)
        else $error("config write not accepted");
    AST_NO_SPUR: assert property (!req.wr |=> !wr_done && !wr_fail)
        else $error("write answer without a write");
    AST_GAP_RD: assert property (req.rd && in_gap |=> mem_rdata == 16'h0000)
        else $error("unmapped read not zero");
    // scan after bus reset
    AST_BUSRST_CLR: assert property (usb_bus_reset |=> !cfg_loaded)
        else $error("bus reset kept settings loaded");
    AST_SCAN_DONE: assert property ($fell(usb_bus_reset) |-> ##[1:140] cfg_loaded)
        else $error("scan did not finish after bus reset");

    // main scenarios
    cover property (req.wr && in_rsvd);
    cover property (req.rd && in_gap);
    cover property ($rose(cfg_loaded));
endmodule // mcg_region_guard_chk

bind mcg_region_guard mcg_region_guard_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .usb_bus_reset(usb_bus_reset), .req(req), .mem_rdata(mem_rdata), .wr_done(wr_done),
    .wr_fail(wr_fail), .cfg_loaded(cfg_loaded));

// *** verification/mcg_host_model.sv ***
`timescale 1ns/1ps
module mcg_host_model
    import mcg_pkg::*;
(
    input  wire logic        core_clk,  // device clock
    output mcg_req_type      req,       // memory request
    input  wire logic [15:0] mem_rdata, // read data
    input  wire logic        wr_done,   // write accepted
    input  wire logic        wr_fail    // write refused
);
    initial req = '0;

    // one write; only the address asked for is ever driven with a strobe
    task automatic wr(input logic [9:0] a, input logic [15:0] d, output logic done, output logic fail);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1;
        done = wr_done;
        fail = wr_fail;
    endtask

    // one read, data taken the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: req.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '{addr: ~a, wdata: ~req.wdata, wr: 1'b0, rd: 1'b0};
        #1;
        d = mem_rdata;
    endtask
endmodule // mcg_host_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    import mcg_pkg::*;
    logic        core_clk;
    logic        reset_n;
    logic        usb_bus_reset;
    mcg_req_type req;
    mcg_act_type act;
    logic [7:0]  line_in;
    logic [7:0]  line_out;
    logic [15:0] mem_rdata;
    logic        wr_done;
    logic        wr_fail;
    logic        cksum_ok;
    logic        cfg_loaded;
    logic [3:0]  cfg_pin;
    logic [15:0] v;
    logic [15:0] c;
    logic [9:0]  ua [4] = '{10'h012, 10'h03E, 10'h080, 10'h3FF};
    int          num_errors;
    int          total_checks;
    int          cycles;

    mcg_region_guard uut (.core_clk(core_clk), .reset_n(reset_n), .usb_bus_reset(usb_bus_reset), .req(req),
        .act(act), .line_in(line_in), .mem_rdata(mem_rdata), .wr_done(wr_done), .wr_fail(wr_fail),
        .cksum_ok(cksum_ok), .cfg_loaded(cfg_loaded), .cfg_pin(cfg_pin), .line_out(line_out));
    mcg_host_model u_host (.core_clk(core_clk), .req(req), .mem_rdata(mem_rdata), .wr_done(wr_done),
        .wr_fail(wr_fail));

    // clock and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // write with expected answer, read with expected data
    task wchk(input logic [9:0] a, input logic [15:0] d, input logic exp_fail);
        logic done, fail;
        u_host.wr(a, d, done, fail);
        `CHK(fail, exp_fail)
        `CHK(done, ~exp_fail)
    endtask
    task rchk(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_host.rd(a, r);
        `CHK(r, exp)
    endtask
    task wait_loaded;
        for (int i = 0; i < 200 && cfg_loaded !== 1'b1; i++)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task t_defaults;
        wait_loaded();
        `CHK(cksum_ok, 1'b1)
        @(posedge core_clk);
        act <= '{rs485_tx_busy: 1'b1, rx_activity: 1'b0, tx_activity: 1'b1, usb_suspend: 1'b0};
        line_in <= 8'hA5;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(cfg_pin, 4'b1011)
        `CHK(line_out, 8'hA5)
        @(posedge core_clk);
        act.usb_suspend <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(cfg_pin, 4'b0011)
        $display("test defaults done");
    endtask

    task t_user;
        foreach (ua[i]) wchk(ua[i], {6'h30, ua[i]}, 1'b0);
        foreach (ua[i]) rchk(ua[i], {6'h30, ua[i]});
        repeat (130) @(posedge core_clk);
        #1;
        `CHK(cksum_ok, 1'b1)
        $display("test user done");
    endtask

    task t_reserved;
        u_host.rd(10'h040, v);
        wchk(10'h040, ~v, 1'b1);
        rchk(10'h040, v);
        wchk(10'h04E, 16'h1234, 1'b1);
        wchk(10'h011, 16'h1234, 1'b1);
        rchk(10'h011, 16'h0000);
        $display("test reserved done");
    endtask

    task t_cfg;
        u_host.rd(MCG_CKSUM_WORD, c);
        u_host.rd(10'h055, v);
        wchk(10'h055, v + 16'h0001, 1'b0);
        rchk(10'h055, v + 16'h0001);
        repeat (130) @(posedge core_clk);
        #1;
        `CHK(cksum_ok, 1'b0)
        wchk(10'h055, v, 1'b0);
        wchk(MCG_PIN_WORD, 16'h4545, 1'b0);
        wchk(MCG_INV_WORD, 16'h0081, 1'b0);
        wchk(MCG_CKSUM_WORD, c - MCG_PIN_DEFAULT - MCG_INV_DEFAULT + 16'h45C6, 1'b0);
        @(posedge core_clk);
        line_in <= 8'h00;
        repeat (130) @(posedge core_clk);
        #1;
        `CHK(cksum_ok, 1'b1)
        `CHK(line_out, 8'h81)
        `CHK(cfg_pin, 4'b0101)
        $display("test config done");
    endtask

    task t_busrst;
        @(posedge core_clk);
        usb_bus_reset <= 1'b1;
        @(posedge core_clk);
        usb_bus_reset <= 1'b0;
        #1;
        `CHK(cfg_loaded, 1'b0)
        wait_loaded();
        `CHK(cfg_loaded, 1'b1)
        `CHK(cksum_ok, 1'b1)
        `CHK(line_out, 8'h81)
        rchk(10'h012, 16'hC012);
        `CHK(cfg_pin, 4'b0101)
        $display("test bus reset done");
    endtask

    // reset, then the scenarios
    initial
    begin
        reset_n = 1'b0;
        usb_bus_reset = 1'b0;
        act = '0;
        line_in = 8'h00;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        t_defaults();
        t_user();
        t_reserved();
        t_cfg();
        t_busrst();
        wrap_up();
    end
endmodule // tb
